// ### hdl/ccirq_pkg.sv
// Package with register map, field positions and reset values for the channel block.
package ccirq_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_PIN_FUNC = 4'h0;
  localparam logic [3:0] ADDR_IRQ_EN0 = 4'h1;
  localparam logic [3:0] ADDR_IRQ_EN1 = 4'h2;
  localparam logic [3:0] ADDR_STATUS0 = 4'h3;
  localparam logic [3:0] ADDR_STATUS1 = 4'h4;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h5;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h6;
  localparam logic [3:0] ADDR_GRA_LO = 4'h7;
  localparam logic [3:0] ADDR_GRA_HI = 4'h8;
  localparam logic [3:0] ADDR_GRB_LO = 4'h9;
  localparam logic [3:0] ADDR_GRB_HI = 4'ha;
  localparam logic [3:0] ADDR_RUN = 4'hb;
  localparam logic [3:0] ADDR_EVT_STAT = 4'hc;
  localparam logic [3:0] ADDR_EVT_EN = 4'hd;
  localparam logic [3:0] ADDR_EVT_CLR = 4'he;
  // Field positions of the pin function field.
  localparam int FS_BIT3 = 3;
  localparam int FS_BIT2 = 2;
  localparam int FS_BIT1 = 1;
  localparam int FS_BIT0 = 0;
  // Field positions of the interrupt enable and status registers.
  localparam int IE_RSV7 = 7;
  localparam int IE_ONE6 = 6;
  localparam int IE_OVF = 4;
  localparam int IE_B = 1;
  localparam int IE_A = 0;
  // Reset values, masks, counter limit and sizes.
  localparam logic [7:0] IE_RESET = 8'h40;
  localparam logic [7:0] IE_RW_MASK = 8'h93;
  localparam logic [7:0] ST_FIXED = 8'hc0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] GR_RESET = 16'hffff;
  localparam int NUM_CHAN = 2;
  localparam int NUM_EVT = 3;
endpackage : ccirq_pkg

// ### hdl/ccirq_top.sv
// Channel capture/compare pin function and per-channel interrupt enables.
`timescale 1ns/1ps
module ccirq_top
  import ccirq_pkg::*;
#(
  parameter int CW = 16
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Channel count enables from the clocking logic.
  input wire logic [NUM_CHAN-1:0] count_tick,
  // Capture/compare pin A of channel 2.
  input wire logic chan2_capcomp_pin_a_in,
  output logic chan2_capcomp_pin_a_out,
  output logic chan2_capcomp_pin_a_oe,
  // Interrupt requests, three per channel.
  output logic [NUM_CHAN-1:0] overflow_irq_req,
  output logic [NUM_CHAN-1:0] reg_b_irq_req,
  output logic [NUM_CHAN-1:0] reg_a_irq_req,
  output logic irq
);

  // Decode helper: compare an address against an index.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction : hit

  // Pin function field of channel 2, register A part.
  logic [3:0] chan2_pin_function_control_reg;
  // Interrupt enable registers, one per channel.
  logic [7:0] ie_reg [NUM_CHAN];
  // Status flags per channel: overflow, B and A.
  logic [NUM_CHAN-1:0] ovf_flag_reg, b_flag_reg, a_flag_reg;
  // Read-as-one markers that arm the zero-write clear.
  logic [NUM_CHAN-1:0] ovf_seen_reg, b_seen_reg, a_seen_reg;
  // Channel counters and general registers.
  logic [CW-1:0] cnt_reg [NUM_CHAN];
  logic [CW-1:0] gra_reg [NUM_CHAN];
  logic [CW-1:0] grb_reg [NUM_CHAN];
  // Run bits per channel.
  logic [NUM_CHAN-1:0] run_reg;
  // Pin input synchroniser and output latch.
  logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
  // Last accepted pin level; a change counts once stages two and three agree.
  logic pin_lvl_reg;
  logic pin_out_reg;
  // Block event status and enable for the summary interrupt.
  logic [NUM_EVT-1:0] evt_stat_reg, evt_en_reg;

  // Field decoding.
  wire capture_mode = chan2_pin_function_control_reg[FS_BIT3];
  wire [1:0] act = chan2_pin_function_control_reg[FS_BIT1:FS_BIT0];
  wire init_lvl = chan2_pin_function_control_reg[FS_BIT2];
  // A single-stage glitch never makes stages two and three agree, so it is ignored.
  wire pin_agree = (pin_s2_reg == pin_s3_reg);
  wire pin_rise = pin_agree & pin_s3_reg & ~pin_lvl_reg;
  wire pin_fall = pin_agree & ~pin_s3_reg & pin_lvl_reg;
  // Edge choice for capture; bit2 plays no part.
  wire cap_edge = capture_mode & (act[1] ? (pin_rise | pin_fall)
                                 : act[0] ? pin_fall
                                 : pin_rise);
  // Channel index of channel 2 in the arrays.
  localparam int C2 = 1;

  // Per-channel events.
  logic [NUM_CHAN-1:0] ovf_evt, a_evt, b_evt;
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_evt
      // A counter write wins over counting, so the count does not wrap in that cycle.
      wire cnt_wr = reg_wr & (hit(reg_addr, ADDR_COUNT_LO) | hit(reg_addr, ADDR_COUNT_HI))
                    & (g == C2);
      assign ovf_evt[g] = run_reg[g] & count_tick[g] & ~cnt_wr
                          & (cnt_reg[g] == COUNT_MAX);
      assign b_evt[g] = run_reg[g] & count_tick[g] & (cnt_reg[g] == grb_reg[g]);
      if (g == C2)
      begin : g_c2
        // Compare match in compare mode, or a capture in capture mode.
        assign a_evt[g] = capture_mode ? cap_edge
          : (run_reg[g] & count_tick[g] & (cnt_reg[g] == gra_reg[g]));
      end
      else
      begin : g_c1
        assign a_evt[g] = run_reg[g] & count_tick[g] & (cnt_reg[g] == gra_reg[g]);
      end
    end
  endgenerate

  // Register port decode.
  wire wr_pf = reg_wr & hit(reg_addr, ADDR_PIN_FUNC);
  wire [NUM_CHAN-1:0] wr_ie = {reg_wr & hit(reg_addr, ADDR_IRQ_EN1),
                               reg_wr & hit(reg_addr, ADDR_IRQ_EN0)};
  wire [NUM_CHAN-1:0] wr_st = {reg_wr & hit(reg_addr, ADDR_STATUS1),
                               reg_wr & hit(reg_addr, ADDR_STATUS0)};
  wire [NUM_CHAN-1:0] rd_st = {reg_rd & hit(reg_addr, ADDR_STATUS1),
                               reg_rd & hit(reg_addr, ADDR_STATUS0)};
  wire sel_ch = (reg_addr == ADDR_IRQ_EN1) || (reg_addr == ADDR_STATUS1);
  wire [7:0] ie_view = (ie_reg[sel_ch] & IE_RW_MASK) | IE_RESET;
  wire [7:0] st_view = ST_FIXED | {3'h0, ovf_flag_reg[sel_ch], 2'h0,
                                   b_flag_reg[sel_ch], a_flag_reg[sel_ch]};
  // Read multiplexer; unmapped addresses read as zero.
  wire [7:0] rd_mux =
    hit(reg_addr, ADDR_PIN_FUNC) ? {4'h0, chan2_pin_function_control_reg} :
    (hit(reg_addr, ADDR_IRQ_EN0) || hit(reg_addr, ADDR_IRQ_EN1)) ? ie_view :
    (hit(reg_addr, ADDR_STATUS0) || hit(reg_addr, ADDR_STATUS1)) ? st_view :
    hit(reg_addr, ADDR_COUNT_LO) ? cnt_reg[C2][7:0] :
    hit(reg_addr, ADDR_COUNT_HI) ? cnt_reg[C2][15:8] :
    hit(reg_addr, ADDR_GRA_LO) ? gra_reg[C2][7:0] :
    hit(reg_addr, ADDR_GRA_HI) ? gra_reg[C2][15:8] :
    hit(reg_addr, ADDR_GRB_LO) ? grb_reg[C2][7:0] :
    hit(reg_addr, ADDR_GRB_HI) ? grb_reg[C2][15:8] :
    hit(reg_addr, ADDR_RUN) ? {6'h00, run_reg} :
    hit(reg_addr, ADDR_EVT_STAT) ? {5'h00, evt_stat_reg} :
    hit(reg_addr, ADDR_EVT_EN) ? {5'h00, evt_en_reg} : 8'h00;

  // Read data register, valid the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // Pin function field and run bits.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan2_pin_function_control_reg <= 4'h0;
      run_reg <= '0;
    end
    else
    begin
      if (wr_pf)
        chan2_pin_function_control_reg <= reg_wdata[3:0];
      if (reg_wr && hit(reg_addr, ADDR_RUN))
        run_reg <= reg_wdata[NUM_CHAN-1:0];
    end
  end

  // Three-stage synchroniser on the capture pin.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
      pin_lvl_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= chan2_capcomp_pin_a_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // The accepted level follows only once the two late stages agree.
      if (pin_agree)
        pin_lvl_reg <= pin_s3_reg;
    end
  end

  // Compare output pin: a field write loads the initial level, a match acts.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_reg <= 1'b0;
      chan2_capcomp_pin_a_oe <= 1'b0;
    end
    else
    begin
      chan2_capcomp_pin_a_oe <= ~capture_mode & (act != 2'b00);
      if (wr_pf)
        pin_out_reg <= reg_wdata[FS_BIT2];
      else if (!capture_mode && a_evt[C2])
      begin
        case (act)
          2'b01: pin_out_reg <= 1'b0;
          2'b10: pin_out_reg <= 1'b1;
          2'b11: pin_out_reg <= ~pin_out_reg;
          default: pin_out_reg <= pin_out_reg;
        endcase
      end
    end
  end
  assign chan2_capcomp_pin_a_out = pin_out_reg;

  // Per-channel registers, counters and flags.
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_ch
      wire wr_cl = reg_wr & hit(reg_addr, ADDR_COUNT_LO) & (g == C2);
      wire wr_ch = reg_wr & hit(reg_addr, ADDR_COUNT_HI) & (g == C2);
      // Enable register: bits 7, 4, 1, 0 store; the rest are fixed.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ie_reg[g] <= 8'h00;
        else if (wr_ie[g])
          ie_reg[g] <= reg_wdata & IE_RW_MASK;
      end
      // Counter with byte writes on channel 2.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          cnt_reg[g] <= COUNT_RESET;
        else if (wr_cl)
          cnt_reg[g][7:0] <= reg_wdata;
        else if (wr_ch)
          cnt_reg[g][15:8] <= reg_wdata;
        else if (run_reg[g] && count_tick[g])
          cnt_reg[g] <= cnt_reg[g] + CW'(1);
      end
      // General registers; register A takes the count on a capture.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          gra_reg[g] <= GR_RESET;
          grb_reg[g] <= GR_RESET;
        end
        else
        begin
          if (g == C2 && cap_edge)
            gra_reg[g] <= cnt_reg[g];
          else if (g == C2 && reg_wr && hit(reg_addr, ADDR_GRA_LO))
            gra_reg[g][7:0] <= reg_wdata;
          else if (g == C2 && reg_wr && hit(reg_addr, ADDR_GRA_HI))
            gra_reg[g][15:8] <= reg_wdata;
          if (g == C2 && reg_wr && hit(reg_addr, ADDR_GRB_LO))
            grb_reg[g][7:0] <= reg_wdata;
          else if (g == C2 && reg_wr && hit(reg_addr, ADDR_GRB_HI))
            grb_reg[g][15:8] <= reg_wdata;
        end
      end
      // Flags: set wins over clear; clear needs a prior read of one.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ovf_flag_reg[g] <= 1'b0;
          b_flag_reg[g] <= 1'b0;
          a_flag_reg[g] <= 1'b0;
          ovf_seen_reg[g] <= 1'b0;
          b_seen_reg[g] <= 1'b0;
          a_seen_reg[g] <= 1'b0;
        end
        else
        begin
          if (ovf_evt[g])
            ovf_flag_reg[g] <= 1'b1;
          else if (wr_st[g] && !reg_wdata[IE_OVF] && ovf_seen_reg[g])
            ovf_flag_reg[g] <= 1'b0;
          if (b_evt[g])
            b_flag_reg[g] <= 1'b1;
          else if (wr_st[g] && !reg_wdata[IE_B] && b_seen_reg[g])
            b_flag_reg[g] <= 1'b0;
          if (a_evt[g])
            a_flag_reg[g] <= 1'b1;
          else if (wr_st[g] && !reg_wdata[IE_A] && a_seen_reg[g])
            a_flag_reg[g] <= 1'b0;
          if (rd_st[g])
          begin
            ovf_seen_reg[g] <= ovf_flag_reg[g];
            b_seen_reg[g] <= b_flag_reg[g];
            a_seen_reg[g] <= a_flag_reg[g];
          end
          else if (wr_st[g])
          begin
            ovf_seen_reg[g] <= 1'b0;
            b_seen_reg[g] <= 1'b0;
            a_seen_reg[g] <= 1'b0;
          end
        end
      end
      // Gated requests to the interrupt controller.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          overflow_irq_req[g] <= 1'b0;
          reg_b_irq_req[g] <= 1'b0;
          reg_a_irq_req[g] <= 1'b0;
        end
        else
        begin
          overflow_irq_req[g] <= ie_reg[g][IE_OVF] & ovf_flag_reg[g];
          reg_b_irq_req[g] <= ie_reg[g][IE_B] & b_flag_reg[g];
          reg_a_irq_req[g] <= ie_reg[g][IE_A] & a_flag_reg[g];
        end
      end
    end
  endgenerate

  // Summary events of channel 2: overflow, B, A. Set wins over clear.
  wire [NUM_EVT-1:0] evt_in = {ovf_evt[C2], b_evt[C2], a_evt[C2]};
  wire [NUM_EVT-1:0] evt_clr = (reg_wr && hit(reg_addr, ADDR_EVT_CLR))
                               ? reg_wdata[NUM_EVT-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_stat_reg <= '0;
      evt_en_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_in;
      if (reg_wr && hit(reg_addr, ADDR_EVT_EN))
        evt_en_reg <= reg_wdata[NUM_EVT-1:0];
      irq <= |(evt_stat_reg & evt_en_reg);
    end
  end

  // Checks.
  a_req_a_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_a_irq_req[C2] |-> $past(ie_reg[C2][IE_A] & a_flag_reg[C2]))
    else $error("Register A request without enable and flag.");
  a_req_b_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_b_irq_req[C2] == $past(ie_reg[C2][IE_B] & b_flag_reg[C2]))
    else $error("Register B request does not follow its gate.");
  a_req_ovf_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    overflow_irq_req[C2] == $past(ie_reg[C2][IE_OVF] & ovf_flag_reg[C2]))
    else $error("Overflow request does not follow its gate.");
  a_wrap_sets_ovf: assert property (
    @(posedge clk) disable iff (!rst_n)
    ovf_evt[C2] |=> ovf_flag_reg[C2] && cnt_reg[C2] == COUNT_RESET)
    else $error("Counter wrap did not set the overflow flag.");
  a_cap_rise: assert property (
    @(posedge clk) disable iff (!rst_n)
    capture_mode && act == 2'b00 && pin_rise |=> a_flag_reg[C2])
    else $error("Rising edge capture missed.");
  a_cap_fall_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    capture_mode && act == 2'b01 && pin_rise |-> !cap_edge)
    else $error("Falling edge mode captured on rise.");
  a_cap_both: assert property (
    @(posedge clk) disable iff (!rst_n)
    capture_mode && act[1] && (pin_rise || pin_fall)
    |=> gra_reg[C2] == $past(cnt_reg[C2]))
    else $error("Both edge capture did not load register A.");
  a_toggle_match: assert property (
    @(posedge clk) disable iff (!rst_n)
    !capture_mode && act == 2'b11 && a_evt[C2] && !wr_pf
    |=> pin_out_reg != $past(pin_out_reg))
    else $error("Toggle on match failed.");
  a_oe_disabled: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(act == 2'b00 || capture_mode) |-> !chan2_capcomp_pin_a_oe)
    else $error("Pin driven while output disabled.");
  a_ie_fixed: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(reg_rd && hit(reg_addr, ADDR_IRQ_EN0))
    |-> reg_rdata[IE_ONE6] && reg_rdata[3:2] == 2'b00)
    else $error("Fixed enable bits read wrong.");
endmodule : ccirq_top

// ### tb/ccirq_pin_model.sv
// Model of the far side of capture/compare pin A: an external driver sharing the pin wire.
`timescale 1ns/1ps
module ccirq_pin_model (
  // Pin drive from the block.
  input wire logic pin_out,
  input wire logic pin_oe,
  // Level that the outside world drives while the block is not driving.
  input wire logic ext_level,
  // Resolved wire level seen by the block.
  output logic pin_level
);
  // The block wins the wire while its enable is high; otherwise the outside level shows.
  assign pin_level = pin_oe ? pin_out : ext_level;
endmodule : ccirq_pin_model

// ### tb/ccirq_top_tb.sv
// Self-checking testbench for the channel pin function and interrupt enable block.
`timescale 1ns/1ps
module ccirq_top_tb;
  import ccirq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] count_tick = 2'b00;
  logic ext_level = 1'b0;
  logic pin_level, pin_out, pin_oe, irq;
  logic [1:0] ovf_req, b_req, a_req;
  logic [7:0] exp_q[$]; // Expected read data, oldest first.
  logic rd_pend = 1'b0; // Read data stands in this cycle.
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'hae54;
  logic [7:0] v;
  logic [3:0] c;
  logic re, fe;
  // Capture codes and compare codes that the scenarios walk through.
  logic [3:0] cap_codes [5] = '{4'h8, 4'h9, 4'ha, 4'he, 4'hb};
  logic [3:0] cmp_codes [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h4, 4'h0};
  // Clock of 10 ns period.
  always #5 clk = ~clk;
  ccirq_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick),
    .chan2_capcomp_pin_a_in(pin_level), .chan2_capcomp_pin_a_out(pin_out),
    .chan2_capcomp_pin_a_oe(pin_oe), .overflow_irq_req(ovf_req), .reg_b_irq_req(b_req),
    .reg_a_irq_req(a_req), .irq(irq));
  ccirq_pin_model u_pin (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_level(pin_level));
  // Compare one value and report a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Print the verdict and end the run.
  task automatic summarize();
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // One write cycle; strobes stay as set until the next bus task or idle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : wr
  // One read cycle; the expected data is queued for the monitor.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Release both strobes and let n edges pass.
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  // Channel-2 count enable held for n cycles.
  task automatic tick(input int n);
    count_tick <= 2'b10;
    repeat (n) @(posedge clk);
    count_tick <= 2'b00;
  endtask : tick
  // Note which edges carried a read, then compare in the following cycle.
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk)
  begin
    if (rd_pend)
    begin
      if (exp_q.size() == 0)
        chk(reg_rdata, 8'hxx);
      else
        chk(reg_rdata, exp_q.pop_front());
    end
  end
  // Cut a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      summarize();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values of both enable registers and both status registers.
    rd(ADDR_IRQ_EN0, 8'h40);
    rd(ADDR_IRQ_EN1, 8'h40);
    rd(ADDR_STATUS0, 8'hc0);
    rd(ADDR_STATUS1, 8'hc0);
    rd(4'hf, 8'h00);
    // Fixed bits 6, 3 and 2 ignore writes (bit 5 is never written as one), bit 7 stores what is written.
    wr(ADDR_IRQ_EN1, 8'hdf);
    rd(ADDR_IRQ_EN1, 8'hd3);
    repeat (6)
    begin
      v = 8'($random(seed)) & 8'hdf;
      wr(ADDR_IRQ_EN0, v);
      rd(ADDR_IRQ_EN0, (v & 8'h93) | 8'h40);
    end
    rd(ADDR_IRQ_EN1, 8'hd3);
    wr(ADDR_IRQ_EN1, 8'h01);
    // Capture codes: flag and request on the selected pin edges only.
    foreach (cap_codes[i])
    begin
      c = cap_codes[i];
      re = c[1] | ~c[0];
      fe = c[1] | c[0];
      wr(ADDR_PIN_FUNC, c);
      idle(8);
      ext_level <= 1'b1;
      idle(8);
      chk({6'h0, a_req}, {6'h0, re, 1'b0});
      rd(ADDR_STATUS1, 8'hc0 | 8'(re));
      wr(ADDR_STATUS1, 8'h00);
      ext_level <= 1'b0;
      idle(8);
      chk({6'h0, a_req}, {6'h0, fe, 1'b0});
      rd(ADDR_STATUS1, 8'hc0 | 8'(fe));
      wr(ADDR_STATUS1, 8'h00);
    end
    rd(ADDR_GRA_HI, 8'h00);
    // Compare codes: initial level, enable and level after one match.
    wr(ADDR_GRA_LO, 8'h01);
    wr(ADDR_GRA_HI, 8'h00);
    wr(ADDR_RUN, 8'h03);
    foreach (cmp_codes[i])
    begin
      c = cmp_codes[i];
      wr(ADDR_COUNT_LO, 8'h00);
      wr(ADDR_COUNT_HI, 8'h00);
      wr(ADDR_PIN_FUNC, c);
      idle(3);
      chk({7'h0, pin_oe}, {7'h0, c[1:0] != 2'b00});
      if (c[1:0] != 2'b00)
        chk({7'h0, pin_out}, {7'h0, c[2]});
      tick(3);
      idle(3);
      if (c[1:0] != 2'b00)
        chk({7'h0, pin_out}, {7'h0, c[1:0] == 2'b11 ? ~c[2] : c[1]});
    end
    rd(ADDR_STATUS1, 8'hc1);
    wr(ADDR_STATUS1, 8'h00);
    // Overflow: flag on wrap, request gated by its enable, interrupt masked and cleared.
    wr(ADDR_IRQ_EN1, 8'h00);
    wr(ADDR_GRA_HI, 8'h80);
    wr(ADDR_EVT_CLR, 8'h07);
    wr(ADDR_COUNT_LO, 8'hff);
    wr(ADDR_COUNT_HI, 8'hff);
    idle(1);
    tick(2);
    idle(3);
    chk({6'h0, ovf_req}, 8'h00);
    // The wrap passes 0xffff, which also matches register B at its reset value.
    rd(ADDR_STATUS1, 8'hd2);
    wr(ADDR_EVT_EN, 8'h04);
    wr(ADDR_IRQ_EN1, 8'h12);
    idle(3);
    chk({6'h0, ovf_req}, 8'h02);
    chk({6'h0, b_req}, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(ADDR_EVT_EN, 8'h00);
    idle(3);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_STATUS1, 8'hd0);
    rd(ADDR_STATUS1, 8'hd0);
    wr(ADDR_STATUS1, 8'h00);
    idle(3);
    chk({6'h0, ovf_req}, 8'h00);
    chk({6'h0, b_req}, 8'h00);
    rd(ADDR_EVT_STAT, 8'h06);
    wr(ADDR_EVT_CLR, 8'h04);
    rd(ADDR_EVT_STAT, 8'h02);
    idle(3);
    summarize();
  end
endmodule : ccirq_top_tb
